// ===== design/smb_master_engine.sv
// Two-wire bus master engine with own-address acknowledge
`timescale 1ns/1ps
module smb_master_engine
	import smb_pkg::*;
#(
	parameter int MS_CYC = CYC_PER_MS
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	input  wire smb_cfg_t    cfg,
	input  wire logic        req_valid,
	input  wire smb_req_t    req,
	output logic             req_ready,
	input  wire logic        wr_valid,
	input  wire logic [7:0]  wr_data,
	output logic             wr_ready,
	output logic             rd_valid,
	output logic [7:0]       rd_data,
	output smb_result_t      result
);
	typedef enum logic [3:0] {
		M_IDLE, M_START, M_LOAD, M_LO, M_HI, M_RS_LO, M_RS_HI, M_SP_LO, M_SP_HI, M_SP_END
	} smb_mst_t;
	typedef enum logic [1:0] {P_ADDR, P_LADDR, P_RADDR, P_DATA} smb_step_t;

	smb_mst_t    state_reg;
	smb_step_t   step_reg;
	smb_req_t    req_reg;
	smb_status_t stat_reg;
	smb_result_t res_reg;
	logic [15:0] cnt_reg;
	logic [3:0]  bit_reg;
	logic [7:0]  tx_reg;
	logic [7:0]  rx_reg;
	logic [9:0]  left_reg;
	logic [4:0]  lleft_reg;
	logic        scl_oe_reg;
	logic        sda_oe_reg;
	logic        zero_reg;
	logic        req_ready_reg;
	logic        wr_ready_reg;
	logic        rd_valid_reg;
	logic [7:0]  rd_data_reg;
	logic        busy_reg;
	logic        scl_d_reg;
	logic        sda_d_reg;
	logic        slv_act_reg;
	logic        slv_ack_reg;
	logic [3:0]  slv_cnt_reg;
	logic [7:0]  slv_sh_reg;
	logic [1:0]  line_s;

	wire logic       scl_s;
	wire logic       sda_s;
	wire logic       in_hi;
	wire logic       in_stop;
	wire logic       cnt_run;
	wire logic       half_done;
	wire logic       first_hi;
	wire logic       hi_end;
	wire logic       last_bit;
	wire logic       last_byte;
	wire logic       rx_mode;
	wire logic       need_wr;
	wire logic       wr_take;
	wire logic       load_go;
	wire logic [7:0] load_byte;
	wire logic       lo_drive;
	wire logic       arb_hit;
	wire logic       nack_hit;
	wire logic       rw_tmo;
	wire logic       low_tmo;
	wire logic       rw_run;
	wire logic [9:0] rw_limit;
	wire logic       start_det;
	wire logic       stop_det;
	wire logic       scl_rise;
	wire logic       scl_fall;
	wire logic       own_hit;

	// Address byte: target in bits 7..1, direction in bit 0
	function automatic logic [7:0] addr_byte(input logic [6:0] target, input logic rd);
		addr_byte = {target, rd ? DIR_READ : DIR_WRITE};
	endfunction : addr_byte

	// Line inputs cross into the core clock
	smb_sync #(
		.W(2)
	) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({scl_in, sda_in}),
		.sync_out (line_s)
	);

	// Transfer timeout, stopped while the STOP is being sent
	smb_tmo #(
		.MS_CYC(MS_CYC)
	) u_rw_tmo (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (rw_run),
		.limit_ms (rw_limit),
		.expired  (rw_tmo)
	);

	// Clock-low timeout
	smb_tmo #(
		.MS_CYC(MS_CYC)
	) u_low_tmo (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (cfg.scl_low_tmo_en && !scl_s),
		.limit_ms (SCL_LOW_TMO_MS),
		.expired  (low_tmo)
	);

	// Line state and bus conditions
	assign scl_s     = line_s[1];
	assign sda_s     = line_s[0];
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;
	assign scl_rise  = scl_s && !scl_d_reg;
	assign scl_fall  = !scl_s && scl_d_reg;

	// Phase timing; high phases wait for the line to really rise
	assign in_hi     = (state_reg == M_HI) || (state_reg == M_RS_HI) || (state_reg == M_SP_HI);
	assign in_stop   = (state_reg == M_SP_LO) || in_hi && (state_reg == M_SP_HI)
		|| (state_reg == M_SP_END);
	assign cnt_run   = !in_hi || scl_s || (cnt_reg != 16'h0000);
	assign half_done = (cnt_reg >= cfg.half_cyc);
	assign first_hi  = scl_s && (cnt_reg == 16'h0000);
	assign hi_end    = half_done || (!scl_s && cnt_reg != 16'h0000);

	// Byte and bit selection
	assign last_bit  = (bit_reg == ACK_BIT_IDX);
	assign last_byte = (left_reg == 10'h001);
	assign rx_mode   = (step_reg == P_DATA) && (req_reg.kind != SMB_WRITE);
	assign need_wr   = (step_reg == P_LADDR) || (step_reg == P_DATA && req_reg.kind == SMB_WRITE);
	assign wr_take   = wr_valid && wr_ready_reg;
	assign load_go   = !need_wr || wr_take;
	assign load_byte = (step_reg == P_ADDR)  ? addr_byte(req_reg.target, req_reg.kind == SMB_READ)
		: (step_reg == P_RADDR) ? addr_byte(req_reg.target, DIR_READ) : wr_data;
	assign lo_drive  = last_bit ? rx_mode : (!rx_mode && !tx_reg[7]);

	// Arbitration, acknowledge and timeout events
	assign arb_hit  = (state_reg == M_HI) && first_hi && !last_bit && !rx_mode
		&& tx_reg[7] && !sda_s;
	assign nack_hit = (state_reg == M_HI) && first_hi && last_bit && !rx_mode && sda_s;
	assign rw_run   = (state_reg != M_IDLE) && !in_stop;
	assign rw_limit = (req_reg.kind == SMB_WRITE) ? cfg.wr_tmo_ms : cfg.rd_tmo_ms;
	assign own_hit  = (slv_sh_reg[7:1] == cfg.own_addr[7:1]);

	// Bit and byte sequencer of the master
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg     <= M_IDLE;
			step_reg      <= P_ADDR;
			req_reg       <= '0;
			stat_reg      <= SMB_OK;
			res_reg       <= '0;
			cnt_reg       <= 16'h0000;
			bit_reg       <= 4'h0;
			tx_reg        <= 8'h00;
			rx_reg        <= 8'h00;
			left_reg      <= 10'h000;
			lleft_reg     <= 5'h00;
			scl_oe_reg    <= 1'b0;
			sda_oe_reg    <= 1'b0;
			req_ready_reg <= 1'b0;
			wr_ready_reg  <= 1'b0;
			rd_valid_reg  <= 1'b0;
			rd_data_reg   <= 8'h00;
		end else begin
			req_ready_reg <= 1'b0;
			wr_ready_reg  <= 1'b0;
			rd_valid_reg  <= 1'b0;
			res_reg.done  <= 1'b0;
			cnt_reg       <= cnt_run ? cnt_reg + 16'h0001 : cnt_reg;
			if ((low_tmo || arb_hit) && state_reg != M_IDLE) begin
				scl_oe_reg <= 1'b0;
				sda_oe_reg <= 1'b0;
				state_reg  <= M_IDLE;
				res_reg    <= '{done: 1'b1, status: arb_hit ? SMB_ARB_LOST : SMB_TIMEOUT};
			end else if (rw_tmo) begin
				stat_reg   <= SMB_TIMEOUT;
				scl_oe_reg <= 1'b1;
				cnt_reg    <= 16'h0000;
				state_reg  <= M_SP_LO;
			end else begin
				unique case (state_reg)
					M_IDLE: begin
						scl_oe_reg <= 1'b0;
						sda_oe_reg <= slv_ack_reg;
						if (req_valid && req_ready_reg) begin
							req_reg   <= req;
							step_reg  <= P_ADDR;
							stat_reg  <= SMB_OK;
							left_reg  <= req.count;
							lleft_reg <= (req.laddr_len > LADDR_MAX) ? LADDR_MAX : req.laddr_len;
							cnt_reg   <= 16'h0000;
							state_reg <= M_START;
						end else begin
							req_ready_reg <= !busy_reg && !slv_act_reg;
						end
					end
					M_START: begin
						sda_oe_reg <= 1'b1;
						if (half_done) begin
							scl_oe_reg <= 1'b1;
							cnt_reg    <= 16'h0000;
							state_reg  <= M_LOAD;
						end
					end
					M_LOAD: begin
						bit_reg      <= 4'h0;
						wr_ready_reg <= need_wr && !wr_take;
						if (load_go) begin
							tx_reg    <= load_byte;
							cnt_reg   <= 16'h0000;
							state_reg <= M_LO;
						end
					end
					M_LO: begin
						sda_oe_reg <= lo_drive;
						if (half_done) begin
							scl_oe_reg <= 1'b0;
							cnt_reg    <= 16'h0000;
							state_reg  <= M_HI;
						end
					end
					M_HI: begin
						if (first_hi && rx_mode && !last_bit) begin
							rx_reg <= {rx_reg[6:0], sda_s};
						end
						if (nack_hit) begin
							stat_reg <= SMB_NACK;
						end
						if (hi_end) begin
							scl_oe_reg <= 1'b1;
							cnt_reg    <= 16'h0000;
							if (!last_bit) begin
								tx_reg    <= {tx_reg[6:0], 1'b0};
								bit_reg   <= bit_reg + 4'h1;
								state_reg <= M_LO;
							end else if (nack_hit || stat_reg == SMB_NACK) begin
								state_reg <= M_SP_LO;
							end else if (rx_mode) begin
								rd_valid_reg <= 1'b1;
								rd_data_reg  <= rx_reg;
								left_reg     <= left_reg - 10'h001;
								state_reg    <= last_byte ? M_SP_LO : M_LOAD;
							end else begin
								unique case (step_reg)
									P_ADDR: begin
										step_reg  <= (req_reg.kind == SMB_ADDR_READ) ? P_LADDR : P_DATA;
										state_reg <= M_LOAD;
									end
									P_LADDR: begin
										lleft_reg <= lleft_reg - 5'h01;
										step_reg  <= (lleft_reg <= 5'h01) ? P_RADDR : P_LADDR;
										state_reg <= (lleft_reg <= 5'h01) ? M_RS_LO : M_LOAD;
									end
									P_RADDR: begin
										step_reg  <= P_DATA;
										state_reg <= M_LOAD;
									end
									P_DATA: begin
										left_reg  <= left_reg - 10'h001;
										state_reg <= last_byte ? M_SP_LO : M_LOAD;
									end
								endcase
							end
						end
					end
					M_RS_LO: begin
						sda_oe_reg <= 1'b0;
						if (half_done) begin
							scl_oe_reg <= 1'b0;
							cnt_reg    <= 16'h0000;
							state_reg  <= M_RS_HI;
						end
					end
					M_RS_HI: begin
						if (half_done) begin
							cnt_reg   <= 16'h0000;
							state_reg <= M_START;
						end
					end
					M_SP_LO: begin
						sda_oe_reg <= 1'b1;
						if (half_done) begin
							scl_oe_reg <= 1'b0;
							cnt_reg    <= 16'h0000;
							state_reg  <= M_SP_HI;
						end
					end
					M_SP_HI: begin
						if (half_done) begin
							sda_oe_reg <= 1'b0;
							cnt_reg    <= 16'h0000;
							state_reg  <= M_SP_END;
						end
					end
					M_SP_END: begin
						if (half_done) begin
							res_reg   <= '{done: 1'b1, status: stat_reg};
							state_reg <= M_IDLE;
						end
					end
				endcase
			end
		end
	end

	// Bus busy tracking and own-address acknowledge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_d_reg   <= 1'b1;
			sda_d_reg   <= 1'b1;
			busy_reg    <= 1'b0;
			slv_act_reg <= 1'b0;
			slv_ack_reg <= 1'b0;
			slv_cnt_reg <= 4'h0;
			slv_sh_reg  <= 8'h00;
		end else begin
			scl_d_reg <= scl_s;
			sda_d_reg <= sda_s;
			busy_reg  <= start_det || (busy_reg && !stop_det && !low_tmo);
			if (stop_det || low_tmo || state_reg != M_IDLE) begin
				slv_act_reg <= 1'b0;
				slv_ack_reg <= 1'b0;
			end else if (start_det) begin
				slv_act_reg <= 1'b1;
				slv_cnt_reg <= 4'h0;
			end else if (slv_act_reg && scl_rise && slv_cnt_reg != ACK_BIT_IDX) begin
				slv_sh_reg  <= {slv_sh_reg[6:0], sda_s};
				slv_cnt_reg <= slv_cnt_reg + 4'h1;
			end else if (slv_act_reg && scl_fall && slv_cnt_reg == ACK_BIT_IDX) begin
				slv_ack_reg <= !slv_ack_reg && own_hit;
				slv_act_reg <= !slv_ack_reg && own_hit;
			end
		end
	end

	// Constant low drive level of both open-drain pins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			zero_reg <= 1'b0;
		end else begin
			zero_reg <= 1'b0;
		end
	end

	assign scl_out   = zero_reg;
	assign sda_out   = zero_reg;
	assign scl_oe    = scl_oe_reg;
	assign sda_oe    = sda_oe_reg;
	assign req_ready = req_ready_reg;
	assign wr_ready  = wr_ready_reg;
	assign rd_valid  = rd_valid_reg;
	assign rd_data   = rd_data_reg;
	assign result    = res_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	sequence s_stop_release;
		(state_reg == M_SP_HI) ##1 (state_reg == M_SP_END);
	endsequence
	sequence s_restart;
		(state_reg == M_RS_HI) ##1 (state_reg == M_START);
	endsequence

	chk_idle_released: assert property ((state_reg == M_IDLE) |=> !scl_oe_reg)
		else $error("clock line driven while idle");
	chk_addr_field: assert property ((state_reg == M_LOAD && step_reg == P_ADDR && load_go)
		|=> tx_reg[7:1] == req_reg.target)
		else $error("address byte lacks target");
	chk_dir_bit: assert property ((state_reg == M_LOAD && step_reg != P_ADDR
		&& step_reg != P_DATA && step_reg != P_LADDR && load_go) |=> tx_reg[DIR_BIT])
		else $error("direction bit not read on readdress");
	chk_master_ack: assert property ((state_reg == M_LO && rx_mode && last_bit)
		|=> sda_oe_reg)
		else $error("master did not acknowledge byte");
	chk_nack_stop: assert property ((state_reg == M_HI && last_bit && hi_end && !low_tmo
		&& stat_reg == SMB_NACK) |=> state_reg == M_SP_LO)
		else $error("not-acknowledge did not lead to stop");
	chk_stop_release: assert property (s_stop_release |-> !scl_oe_reg && !$past(scl_oe_reg))
		else $error("data released while clock low in stop");
	chk_restart_path: assert property (s_restart |-> step_reg == P_RADDR)
		else $error("repeated start outside addressed read");
	chk_arb_release: assert property (arb_hit |=> state_reg == M_IDLE && !scl_oe_reg
		&& !sda_oe_reg && res_reg.done && res_reg.status == SMB_ARB_LOST)
		else $error("lost arbitration not released and reported");
	chk_clk_sync: assert property ((state_reg == M_HI && cnt_reg != 16'h0000 && !scl_s)
		|=> scl_oe_reg)
		else $error("clock not pulled low after another driver");
	chk_own_ack: assert property ($rose(slv_ack_reg) |-> own_hit && state_reg == M_IDLE)
		else $error("acknowledge given to a foreign address");
	chk_tmo_abort: assert property ((low_tmo && state_reg != M_IDLE && !arb_hit)
		|=> state_reg == M_IDLE && res_reg.status == SMB_TIMEOUT)
		else $error("clock-low timeout did not reset transfer");
	chk_rw_tmo: assert property ((rw_tmo && !low_tmo && !arb_hit) |=> state_reg == M_SP_LO
		&& stat_reg == SMB_TIMEOUT)
		else $error("transfer timeout did not cancel");
	chk_wr_take: assert property (wr_take |-> state_reg == M_LOAD && need_wr)
		else $error("write byte taken out of turn");
endmodule : smb_master_engine

// ===== design/smb_pkg.sv
// Shared types and constants for the two-wire master engine
package smb_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS         = 1000000;
	localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
	// Clock-low timeout and recovery bound, in milliseconds
	localparam logic [9:0] SCL_LOW_TMO_MS  = 10'h019;
	localparam int         RECOVER_MAX_MS  = 10;
	// Address byte layout and direction codes
	localparam int         DIR_BIT     = 0;
	localparam logic       DIR_READ    = 1'b1;
	localparam logic       DIR_WRITE   = 1'b0;
	localparam logic [3:0] ACK_BIT_IDX = 4'h8;
	localparam logic [4:0] LADDR_MAX   = 5'h10;

	typedef enum logic [1:0] {SMB_WRITE, SMB_READ, SMB_ADDR_READ} smb_kind_t;
	typedef enum logic [1:0] {SMB_OK, SMB_NACK, SMB_ARB_LOST, SMB_TIMEOUT} smb_status_t;

	// One transfer request from the internal controller
	typedef struct packed {
		smb_kind_t  kind;
		logic [6:0] target;
		logic [9:0] count;
		logic [4:0] laddr_len;
	} smb_req_t;

	// Static configuration, held stable while a transfer runs
	typedef struct packed {
		logic [7:0]  own_addr;
		logic [15:0] half_cyc;
		logic [9:0]  rd_tmo_ms;
		logic [9:0]  wr_tmo_ms;
		logic        scl_low_tmo_en;
	} smb_cfg_t;

	// Completion report
	typedef struct packed {
		logic        done;
		smb_status_t status;
	} smb_result_t;
endpackage : smb_pkg

// ===== design/smb_sync.sv
// Two-stage synchroniser for the bus line inputs
`timescale 1ns/1ps
module smb_sync #(
	parameter int W = 2
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// Idle bus reads high, so reset to ones
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule : smb_sync

// ===== design/smb_tmo.sv
// Millisecond timeout counter with a programmable limit
`timescale 1ns/1ps
module smb_tmo
	import smb_pkg::*;
#(
	parameter int MS_CYC = CYC_PER_MS
) (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [9:0] limit_ms,
	output logic            expired
);
	localparam int            PW       = $clog2(MS_CYC + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(MS_CYC - 1);

	logic [PW-1:0] pre_reg;
	logic [9:0]    ms_reg;
	logic          exp_reg;
	wire logic     tick;
	wire logic     at_limit;

	// Zero limit disables the timer
	assign tick     = (pre_reg == PRE_LAST);
	assign at_limit = (limit_ms != 10'h000) && (ms_reg >= limit_ms);

	// Prescale to milliseconds while running, clear when stopped
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pre_reg <= '0;
			ms_reg  <= 10'h000;
			exp_reg <= 1'b0;
		end else if (!run) begin
			pre_reg <= '0;
			ms_reg  <= 10'h000;
			exp_reg <= 1'b0;
		end else begin
			pre_reg <= tick ? '0 : pre_reg + PW'(1);
			if (tick && !at_limit) begin
				ms_reg <= ms_reg + 10'h001;
			end
			exp_reg <= at_limit;
		end
	end

	assign expired = exp_reg;
endmodule : smb_tmo

// ===== dv/smb_master_engine_test.sv
// Self-checking bench for the two-wire master engine
`timescale 1ns/1ps
module smb_master_engine_test
	import smb_pkg::*;
;
	localparam int MS_SIM   = 10;
	localparam int WAIT_MAX = 20000;
	logic        core_clk   = 1'b0;
	logic        rst        = 1'b1;
	smb_cfg_t    cfg;
	smb_req_t    req;
	logic        req_valid  = 1'b0;
	logic        wr_valid   = 1'b0;
	logic [7:0]  wr_data    = 8'h00;
	logic        scl_out, scl_oe, sda_out, sda_oe, req_ready, wr_ready, rd_valid, slv_sda;
	logic [7:0]  rd_data;
	smb_result_t result;
	logic        tb_scl_low = 1'b0;
	logic        tb_sda_low = 1'b0;
	wire logic   scl_w      = ~(scl_oe | tb_scl_low);
	wire logic   sda_w      = ~(sda_oe | slv_sda | tb_sda_low);
	logic [7:0]  exp_q[$], wr_q[$], rx_exp[$];
	int          llen[2]    = '{1, 16};
	int          fail_count = 0;
	int          n_compared = 0;

	smb_master_engine #(.MS_CYC(MS_SIM)) DUT (.core_clk(core_clk), .rst(rst),
		.scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .cfg(cfg), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .result(result));
	smb_slave_model #(.ADDR(7'h3A)) slave (.scl(scl_w), .sda(sda_w), .sda_pull(slv_sda));

	// Core clock, 10 ns period
	initial forever #5 core_clk = ~core_clk;

	task automatic stop_test();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test

	task automatic check(string name, logic [7:0] seen, logic [7:0] expd);
		n_compared++;
		if (seen !== expd) begin
			fail_count++;
			$display("Error %s expected %h seen %h", name, expd, seen);
		end
	endtask : check

	function automatic logic [7:0] pop_exp();
		return exp_q.size() ? exp_q.pop_front() : 8'hXX;
	endfunction : pop_exp

	// Write byte feeder, held until the engine takes it
	always @(posedge core_clk) begin
		if (wr_valid && wr_ready)
			void'(wr_q.pop_front());
		wr_valid <= wr_q.size() != 0;
		wr_data <= wr_q.size() ? wr_q[0] : 8'h00;
	end

	// Compare each reported result with the oldest note
	always @(posedge core_clk) begin
		if (rd_valid === 1'b1)
			check("rd_data", rd_data, pop_exp());
		if (result.done === 1'b1)
			check("status", {6'h00, result.status}, pop_exp());
	end

	task automatic run(smb_kind_t k, logic [6:0] t, logic [9:0] n, logic [4:0] l);
		int i;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req <= '{kind: k, target: t, count: n, laddr_len: l};
		for (i = 0; i < WAIT_MAX; i++) begin
			@(posedge core_clk);
			if (req_ready === 1'b1)
				break;
		end
		req_valid <= 1'b0;
		for (i = 0; i < WAIT_MAX && result.done !== 1'b1; i++)
			@(negedge core_clk);
		if (i == WAIT_MAX) begin
			fail_count++;
			stop_test();
		end
		repeat (2) @(negedge core_clk);
		check("idle_lines", {6'h00, scl_oe, sda_oe}, 8'h00);
		check("low_level", {6'h00, scl_out, sda_out}, 8'h00);
	endtask : run

	task automatic chk_rx();
		check("rx_count", 8'(slave.rx_q.size()), 8'(rx_exp.size()));
		foreach (rx_exp[i])
			check("rx_byte", slave.rx_q[i], rx_exp[i]);
		check("master_ack", 8'(slave.mack_err), 8'h00);
		slave.rx_q.delete();
		rx_exp.delete();
	endtask : chk_rx

	task automatic wait_scl_low();
		for (int i = 0; i < WAIT_MAX && scl_w !== 1'b0; i++)
			@(negedge core_clk);
		@(posedge core_clk);
	endtask : wait_scl_low

	// Another master addresses the engine, then sends one data byte
	task automatic own_probe();
		logic [15:0] w;
		logic        d;
		w = {7'h29, 1'b0, 8'hA5};
		// Offset keeps line changes off the core clock edges
		#1;
		tb_sda_low = 1'b1;
		#62.5 tb_scl_low = 1'b1;
		for (int i = 0; i < 18; i++) begin
			d = (i % 9 == 8) ? 1'b1 : w[15 - i + i / 9];
			tb_sda_low = ~d;
			#62.5 tb_scl_low = 1'b0;
			#30;
			if (i % 9 == 8)
				check("own_ack", {7'h00, sda_oe}, (i == 8) ? 8'h01 : 8'h00);
			#32.5 tb_scl_low = 1'b1;
		end
		tb_sda_low = 1'b1;
		#62.5 tb_scl_low = 1'b0;
		#62.5 tb_sda_low = 1'b0;
		#500;
		slave.rx_q.delete();
	endtask : own_probe

	initial begin
		logic [7:0] b;
		int         n;
		cfg = '{own_addr: 8'h53, half_cyc: 16'h0005, rd_tmo_ms: 10'h000, wr_tmo_ms: 10'h000,
			scl_low_tmo_en: 1'b1};
		req = '{kind: SMB_WRITE, target: 7'h00, count: 10'h001, laddr_len: 5'h01};
		void'($urandom(28771));
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		// Write of two random bytes
		rx_exp.push_back(8'h74);
		repeat (2) begin
			b = 8'($urandom);
			wr_q.push_back(b);
			rx_exp.push_back(b);
		end
		exp_q.push_back({6'h00, SMB_OK});
		// Another driver cuts the first high phase short
		fork
			run(SMB_WRITE, 7'h3A, 10'h002, 5'h01);
			begin
				wait_scl_low();
				for (n = 0; n < WAIT_MAX && scl_w !== 1'b1; n++)
					@(posedge core_clk);
				repeat (2) @(posedge core_clk);
				tb_scl_low <= 1'b1;
				repeat (4) @(posedge core_clk);
				tb_scl_low <= 1'b0;
			end
		join
		chk_rx();
		// Read of three random bytes
		rx_exp.push_back(8'h75);
		repeat (3) begin
			b = 8'($urandom);
			slave.tx_q.push_back(b);
			exp_q.push_back(b);
		end
		exp_q.push_back({6'h00, SMB_OK});
		run(SMB_READ, 7'h3A, 10'h003, 5'h01);
		chk_rx();
		// Addressed reads with shortest and longest logical address
		foreach (llen[j]) begin
			rx_exp.push_back(8'h74);
			for (int i = 0; i < llen[j]; i++) begin
				b = 8'($urandom);
				wr_q.push_back(b);
				rx_exp.push_back(b);
			end
			rx_exp.push_back(8'h75);
			b = 8'($urandom);
			slave.tx_q.push_back(b);
			exp_q.push_back(b);
			exp_q.push_back({6'h00, SMB_OK});
			run(SMB_ADDR_READ, 7'h3A, 10'h001, 5'(llen[j]));
			chk_rx();
		end
		// Absent target leaves the address unacknowledged
		rx_exp.push_back(8'h2A);
		exp_q.push_back({6'h00, SMB_NACK});
		run(SMB_WRITE, 7'h15, 10'h001, 5'h01);
		chk_rx();
		own_probe();
		// Another master holds SDA low while the engine sends a one
		exp_q.push_back({6'h00, SMB_ARB_LOST});
		fork
			run(SMB_WRITE, 7'h7F, 10'h001, 5'h01);
			begin
				wait_scl_low();
				tb_sda_low <= 1'b1;
			end
		join
		tb_sda_low <= 1'b0;
		repeat (20) @(posedge core_clk);
		slave.rx_q.delete();
		// Write limit, not the read limit, cancels a write to an absent target
		@(posedge core_clk);
		cfg.wr_tmo_ms <= 10'h001;
		cfg.rd_tmo_ms <= 10'h3E8;
		exp_q.push_back({6'h00, SMB_TIMEOUT});
		run(SMB_WRITE, 7'h15, 10'h001, 5'h01);
		chk_rx();
		@(posedge core_clk);
		cfg.wr_tmo_ms <= 10'h000;
		cfg.rd_tmo_ms <= 10'h000;
		// Clock held low past the limit ends the transfer
		exp_q.push_back({6'h00, SMB_TIMEOUT});
		fork
			run(SMB_WRITE, 7'h15, 10'h001, 5'h01);
			begin
				wait_scl_low();
				tb_scl_low <= 1'b1;
				for (n = 0; n < WAIT_MAX && result.done !== 1'b1; n++)
					@(negedge core_clk);
				check("tmo_window", {7'h00, n >= 25 * MS_SIM - 10 && n <= 35 * MS_SIM},
					8'h01);
			end
		join
		tb_scl_low <= 1'b0;
		repeat (20) @(posedge core_clk);
		check("exp_left", 8'(exp_q.size()), 8'h00);
		stop_test();
	end
endmodule : smb_master_engine_test

// ===== dv/smb_slave_model.sv
// Behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module smb_slave_model #(
	parameter logic [6:0] ADDR = 7'h3A
) (
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_pull
);
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];
	int         mack_err = 0;
	bit         again;

	// Shift in one byte on rising SCL, MSB first
	task automatic get_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
	endtask : get_byte

	// Hold SDA low for the acknowledge bit
	task automatic give_ack();
		@(negedge scl);
		sda_pull = 1'b1;
		@(negedge scl);
		sda_pull = 1'b0;
	endtask : give_ack

	// One frame: address, then data in the requested direction
	task automatic serve();
		logic [7:0] b;
		get_byte(b);
		rx_q.push_back(b);
		if (b[7:1] == ADDR) begin
			give_ack();
			if (b[0]) begin
				while (tx_q.size() != 0) begin
					b = tx_q.pop_front();
					for (int i = 7; i >= 0; i--) begin
						sda_pull = ~b[i];
						@(negedge scl);
					end
					sda_pull = 1'b0;
					@(posedge scl);
					if (sda !== 1'b0)
						mack_err++;
					@(negedge scl);
				end
			end else begin
				forever begin
					get_byte(b);
					rx_q.push_back(b);
					give_ack();
				end
			end
		end
	endtask : serve

	// START opens a frame; STOP or repeated START closes it
	initial begin
		sda_pull = 1'b0;
		again = 1'b0;
		forever begin
			if (!again)
				@(negedge sda iff scl === 1'b1);
			again = 1'b0;
			fork : frame
				serve();
				@(posedge sda iff scl === 1'b1);
				begin
					@(negedge sda iff scl === 1'b1);
					again = 1'b1;
				end
			join_any
			disable frame;
			sda_pull = 1'b0;
		end
	end
endmodule : smb_slave_model
